// ==== slm_defines.vh ====
// Purpose: Constants for the supply level monitor register block
// Assumes: AHB-Lite word-per-register map, byte address = 4 * index
// Notes: Definitions only
`ifndef SLM_DEFINES_VH
`define SLM_DEFINES_VH
`define SLM_IDX_LEVEL_CTRL 4'h1
`define SLM_IDX_MON_CTRL 4'h8
`define SLM_IDX_IRQ_CTRL 4'h9
`define SLM_IDX_IRQ_FLAGS 4'hA
`define SLM_IDX_STATUS 4'hB
`define SLM_IDX_IRQ_MASK 4'hC
`define SLM_IDX_IRQ_STAT 4'hD
`define SLM_LVL_LSB 0
`define SLM_LVL_MSB 2
`define SLM_MARGIN_LSB 0
`define SLM_MARGIN_MSB 1
`define SLM_IE_BIT 0
`define SLM_DIR_LSB 1
`define SLM_DIR_MSB 2
`define SLM_FLAG_BIT 0
`define SLM_STATUS_BIT 0
`define SLM_MARGIN_RST 2'h0
`define SLM_IRQCTRL_RST 2'h0
`define SLM_DIR_FALL 2'h0
`define SLM_DIR_RISE 2'h1
`define SLM_DIR_BOTH 2'h2
`define SLM_MARGIN_5 2'h0
`define SLM_MARGIN_15 2'h1
`define SLM_MARGIN_25 2'h2
`define SLM_EV_FLAG 0
`define SLM_EV_CROSS 1
`endif

// ==== slm_regs.v ====
// Purpose: Register bank of a brown-out detector level select and supply level monitor
// Assumes: One 40 MHz clock, synchronous active-high reset, AHB-Lite slave with zero wait states
// Notes: Comparator input is asynchronous and is synchronised before use
`timescale 1ns/10ps
`default_nettype none
`include "slm_defines.vh"
module slm_regs #(
    parameter LEVEL_WIDTH = 3
) (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // AHB-Lite slave
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    // Detector configuration and comparator
    input wire [LEVEL_WIDTH-1:0] FUSE_LEVEL,
    input wire DETECTOR_ENABLED,
    input wire SUPPLY_BELOW_RAW,
    // Analog control
    output reg [LEVEL_WIDTH-1:0] THRESHOLD_LEVEL_SEL,
    output reg [1:0] MONITOR_MARGIN_SEL,
    output wire MONITOR_ACTIVE,
    // Interrupts
    output wire MONITOR_IRQ,
    output wire IRQ
);

    reg [1:0] crossing_direction_sel;
    reg monitor_irq_enable;
    reg monitor_irq_flag;
    reg [1:0] ev_stat;
    reg [1:0] ev_mask;
    reg below_meta;
    reg below_sync;
    reg below_prev;
    reg det_meta;
    reg det_sync;
    reg fuse_taken;
    reg wr_pend;
    reg [3:0] wr_idx;
    reg rd_stat_pend;
    wire trig;
    wire fall;
    wire rise;
    wire acc;
    wire [3:0] idx;
    wire [31:0] rdata;

    // Word index from the byte address; low address bits ignored for word access
    function [3:0] slm_index;
        input [31:0] a;
        begin
            slm_index = (a[31:6] == 26'h0) ? a[5:2] : 4'hF;
        end
    endfunction

    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign acc = HSEL & HREADY & HTRANS[1];
    assign idx = slm_index(HADDR);

    // Two-flop synchronisers for the analog side
    always @(posedge CLK) begin
        if (RST) begin
            below_meta <= 1'b0;
            below_sync <= 1'b0;
            det_meta <= 1'b0;
            det_sync <= 1'b0;
        end else begin
            below_meta <= SUPPLY_BELOW_RAW;
            below_sync <= below_meta;
            det_meta <= DETECTOR_ENABLED;
            det_sync <= det_meta;
        end
    end

    assign MONITOR_ACTIVE = det_sync & monitor_irq_enable;

    // Previous level tracks only while the detector is enabled, so re-enabling the interrupt does not fake an edge
    always @(posedge CLK) begin
        if (RST) begin
            below_prev <= 1'b0;
        end else if (det_sync) begin
            below_prev <= below_sync;
        end
    end

    // Falling supply means going below the threshold
    assign fall = below_sync & ~below_prev;
    assign rise = ~below_sync & below_prev;
    assign trig = MONITOR_ACTIVE & (
        (crossing_direction_sel == `SLM_DIR_FALL & fall) |
        (crossing_direction_sel == `SLM_DIR_RISE & rise) |
        (crossing_direction_sel == `SLM_DIR_BOTH & (fall | rise)));

    // Fuse level is captured by a clocked load after reset release, not by reset itself
    always @(posedge CLK) begin
        if (RST) begin
            fuse_taken <= 1'b0;
            THRESHOLD_LEVEL_SEL <= {LEVEL_WIDTH{1'b0}};
        end else if (!fuse_taken) begin
            fuse_taken <= 1'b1;
            THRESHOLD_LEVEL_SEL <= FUSE_LEVEL;
        end
    end

    // Address phase capture
    always @(posedge CLK) begin
        if (RST) begin
            wr_pend <= 1'b0;
            wr_idx <= 4'h0;
            rd_stat_pend <= 1'b0;
        end else begin
            wr_pend <= acc & HWRITE;
            wr_idx <= idx;
            rd_stat_pend <= acc & ~HWRITE & (idx == `SLM_IDX_IRQ_STAT);
        end
    end

    // Writable registers
    always @(posedge CLK) begin
        if (RST) begin
            MONITOR_MARGIN_SEL <= `SLM_MARGIN_RST;
            crossing_direction_sel <= `SLM_IRQCTRL_RST;
            monitor_irq_enable <= 1'b0;
            ev_mask <= 2'h0;
        end else if (wr_pend) begin
            case (wr_idx)
                `SLM_IDX_MON_CTRL: begin
                    MONITOR_MARGIN_SEL <= HWDATA[`SLM_MARGIN_MSB:`SLM_MARGIN_LSB];
                end
                `SLM_IDX_IRQ_CTRL: begin
                    crossing_direction_sel <= HWDATA[`SLM_DIR_MSB:`SLM_DIR_LSB];
                    monitor_irq_enable <= HWDATA[`SLM_IE_BIT];
                end
                `SLM_IDX_IRQ_MASK: begin
                    ev_mask <= HWDATA[1:0];
                end
                default: begin
                    ev_mask <= ev_mask;
                end
            endcase
        end
    end

    // Flag: write one clears, trigger wins
    always @(posedge CLK) begin
        if (RST) begin
            monitor_irq_flag <= 1'b0;
        end else if (trig) begin
            monitor_irq_flag <= 1'b1;
        end else if (wr_pend && wr_idx == `SLM_IDX_IRQ_FLAGS && HWDATA[`SLM_FLAG_BIT]) begin
            monitor_irq_flag <= 1'b0;
        end
    end

    // Sticky event status, cleared by reading; a new event in the read cycle survives
    always @(posedge CLK) begin
        if (RST) begin
            ev_stat <= 2'h0;
        end else begin
            ev_stat[`SLM_EV_FLAG] <= (ev_stat[`SLM_EV_FLAG] & ~rd_stat_pend) | trig;
            ev_stat[`SLM_EV_CROSS] <= (ev_stat[`SLM_EV_CROSS] & ~rd_stat_pend) | (det_sync & (fall | rise));
        end
    end

    assign MONITOR_IRQ = monitor_irq_enable & monitor_irq_flag;
    assign IRQ = |(ev_stat & ev_mask);

    // Read mux; status is forced low while the detector is off
    assign rdata =
        (idx == `SLM_IDX_LEVEL_CTRL) ? {{(32-LEVEL_WIDTH){1'b0}}, THRESHOLD_LEVEL_SEL} :
        (idx == `SLM_IDX_MON_CTRL) ? {30'h0, MONITOR_MARGIN_SEL} :
        (idx == `SLM_IDX_IRQ_CTRL) ? {29'h0, crossing_direction_sel, monitor_irq_enable} :
        (idx == `SLM_IDX_IRQ_FLAGS) ? {31'h0, monitor_irq_flag} :
        (idx == `SLM_IDX_STATUS) ? {31'h0, det_sync & below_sync} :
        (idx == `SLM_IDX_IRQ_MASK) ? {30'h0, ev_mask} :
        (idx == `SLM_IDX_IRQ_STAT) ? {30'h0, ev_stat} :
        32'h0;

    always @(posedge CLK) begin
        if (RST) begin
            HRDATA <= 32'h0;
        end else if (acc && !HWRITE) begin
            HRDATA <= rdata;
        end
    end

endmodule
`default_nettype wire

// ==== slm_regs_assertions.sv ====
// Purpose: Port assertions for slm_regs
// Assumes: Writes land one edge after the address phase
// Notes: Inputs pass a 2-flop sync, so gates look two edges back
`timescale 1ns/10ps
`default_nettype none
module slm_regs_chk #(
    parameter LEVEL_WIDTH = 3
) (
    // Clock and bus
    input wire CLK,
    input wire RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [31:0] HWDATA,
    // Monitor
    input wire DETECTOR_ENABLED,
    input wire [LEVEL_WIDTH-1:0] FUSE_LEVEL,
    input wire [LEVEL_WIDTH-1:0] THRESHOLD_LEVEL_SEL,
    input wire [1:0] MONITOR_MARGIN_SEL,
    input wire MONITOR_ACTIVE,
    input wire MONITOR_IRQ
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_wr_margin;
        HSEL && HTRANS[1] && HWRITE && HADDR == 32'h20;
    endsequence
    a_level_fuse: assert property ($fell(RST) |=> THRESHOLD_LEVEL_SEL == $past(FUSE_LEVEL))
        else $error("level not loaded from fuse");
    a_level_ro: assert property (!$past(RST) && !$past(RST, 2) |-> $stable(THRESHOLD_LEVEL_SEL))
        else $error("level changed");
    a_margin_write: assert property (s_wr_margin ##1 1 |=> MONITOR_MARGIN_SEL == $past(HWDATA[1:0]))
        else $error("margin write lost");
    a_margin_hold: assert property (!$past(HSEL) && !$past(HSEL, 2) |-> $stable(MONITOR_MARGIN_SEL))
        else $error("margin changed without write");
    a_active_gate: assert property (MONITOR_ACTIVE |-> $past(DETECTOR_ENABLED, 2))
        else $error("monitor active while detector off");
    a_flag_gate: assert property ($rose(MONITOR_IRQ) && !$past(HSEL, 2) |-> $past(MONITOR_ACTIVE))
        else $error("flag set while monitor inactive");
    a_irq_sticky: assert property (MONITOR_IRQ && !HSEL && !$past(HSEL) |=> MONITOR_IRQ)
        else $error("request dropped without clear");
    a_irq_clear: assert property ($fell(MONITOR_IRQ) |-> $past(HSEL, 2) && $past(HWRITE, 2))
        else $error("request fell without a write");
endmodule
`default_nettype wire

// ==== slm_regs_bench.sv ====
// Purpose: Self-checking bench for slm_regs
// Assumes: Zero-wait slave, level and sync inputs
// Notes: Waits of 5 cover the 2-flop input sync
`timescale 1ns/10ps
`default_nettype none
module slm_regs_bench;
    logic clk = 0, rst = 1, hsel = 0, hwrite = 0, det = 0, below = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [2:0] fuse = 3'h7;
    wire [31:0] hrdata;
    wire hready, hresp, mact, mirq, irq;
    wire [2:0] lvl;
    wire [1:0] marg;
    int num_errors = 0, samples_checked = 0, cyc = 0, d;
    slm_regs slm_regs_inst (.CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .FUSE_LEVEL(fuse), .DETECTOR_ENABLED(det), .SUPPLY_BELOW_RAW(below), .THRESHOLD_LEVEL_SEL(lvl),
        .MONITOR_MARGIN_SEL(marg), .MONITOR_ACTIVE(mact), .MONITOR_IRQ(mirq), .IRQ(irq));
    initial forever #12.5 clk = ~clk;
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task xfer(input logic w, input logic [3:0] i, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {26'h0, i, 2'h0};
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Ceiling well above the ~170 cycles the sequence needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        xfer(1, 4'h1, 32'h0);
        xfer(0, 4'h1, 32'h0);
        chk(rd, 32'h7);
        chk(lvl, 3'h7);
        for (d = 8; d < 12; d++) begin
            xfer(0, d[3:0], 32'h0);
            chk(rd, 32'h0);
        end
        for (d = 0; d < 3; d++) begin
            xfer(1, 4'h8, 32'(d));
            xfer(0, 4'h8, 32'h0);
            chk(rd, 32'(d));
            chk(marg, 32'(d));
        end
        det <= 1;
        xfer(1, 4'hC, 32'h2);
        for (d = 0; d < 3; d++) begin
            xfer(1, 4'h9, 32'(d * 2 + 1));
            xfer(1, 4'hA, 32'h1);
            below <= 1;
            repeat (5) @(posedge clk);
            xfer(0, 4'hA, 32'h0);
            chk(rd, 32'(d != 1));
            chk(mirq, 32'(d != 1));
            chk(mact, 1'b1);
            xfer(0, 4'hB, 32'h0);
            chk(rd, 32'h1);
            xfer(1, 4'hA, 32'h1);
            xfer(0, 4'hA, 32'h0);
            chk(rd, 32'h0);
            below <= 0;
            repeat (5) @(posedge clk);
            xfer(0, 4'hA, 32'h0);
            chk(rd, 32'(d != 0));
        end
        chk(irq, 1'b1);
        xfer(0, 4'hD, 32'h0);
        chk(rd[1], 1'b1);
        @(negedge clk);
        chk(irq, 1'b0);
        xfer(1, 4'hC, 32'h0);
        xfer(0, 4'hF, 32'h0);
        chk(rd, 32'h0);
        xfer(1, 4'hA, 32'h1);
        det <= 0;
        repeat (4) @(posedge clk);
        chk(mact, 1'b0);
        below <= 1;
        repeat (5) @(posedge clk);
        chk(irq, 1'b0);
        chk(mirq, 1'b0);
        xfer(0, 4'hA, 32'h0);
        chk(rd, 32'h0);
        xfer(0, 4'hB, 32'h0);
        chk(rd, 32'h0);
        end_sim();
    end
endmodule
bind slm_regs slm_regs_chk #(.LEVEL_WIDTH(LEVEL_WIDTH)) slm_regs_chk_inst (.CLK(CLK), .RST(RST), .HSEL(HSEL),
    .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .DETECTOR_ENABLED(DETECTOR_ENABLED),
    .FUSE_LEVEL(FUSE_LEVEL),
    .THRESHOLD_LEVEL_SEL(THRESHOLD_LEVEL_SEL), .MONITOR_MARGIN_SEL(MONITOR_MARGIN_SEL),
    .MONITOR_ACTIVE(MONITOR_ACTIVE), .MONITOR_IRQ(MONITOR_IRQ));
`default_nettype wire
